// File: verif/spp_checker.sv
/* Port checker for spp_top: pin polarity, pin role and APB answers.
   Assumes a bind into spp_top, one reset, and pins held still while CE is low. */
`timescale 1ns/1ns
`include "spp_defines.vh"
module spp_checker (
   // Clock, reset and bus
   input wire logic                   CLK, SRST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
   input wire logic [`SPP_ADDR_W-1:0] PADDR,
   input wire logic [`SPP_DATA_W-1:0] PWDATA, PRDATA,
   input wire logic [3:0]             PSTRB,
   // Pin and serial unit paths
   input wire logic                   RX_CH1_PIN, RX_CH2_PIN, RX_CH1_DATA, RX_CH2_DATA,
   input wire logic                   TX_CH1_DATA, TX_CH2_DATA, PORT3_BIT5_OUT, PORT3_BIT5_DIR,
   input wire logic                   PORT4_BIT2_OUT, PORT4_BIT2_DIR, PORT3_BIT5_PIN_O,
   input wire logic                   PORT3_BIT5_PIN_OE, PORT4_BIT2_PIN_O, PORT4_BIT2_PIN_OE,
   input wire logic [7:0]             WAKEUP_INPUT_PINS, WAKEUP_LEVEL
);
   logic [5:0] c;   // Shadow of control bits
   logic [7:0] wk;  // Shadow of wake-up inversion
   logic [1:0] age; // Synchronisers hold reset zeros while this is below 2; it saturates at 3
   wire wr  = PSEL && PENABLE && PWRITE && PSTRB[0] && CE;
   wire map = PADDR == 18'h3fe44 || PADDR == 18'h3fe4c || PADDR == 18'h3fe50;
   // Shadow registers follow completed writes
   always_ff @(posedge CLK) begin
      if (SRST) begin
         c <= '0;
         wk <= '0;
         age <= '0;
      end else begin
         if (age != 2'h3) age <= age + 2'h1;
         if (wr && PADDR == 18'h3fe44) c <= PWDATA[5:0];
         if (wr && PADDR == 18'h3fe4c) wk <= PWDATA[7:0];
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   a_rx1_inv: assert property (age == 2'h3 && $stable(RX_CH1_PIN) && $past(RX_CH1_PIN, 2) == RX_CH1_PIN
      |-> RX_CH1_DATA == (RX_CH1_PIN ^ c[0])) else $error("rx1 polarity wrong");
   a_rx2_inv: assert property (age == 2'h3 && $stable(RX_CH2_PIN) && $past(RX_CH2_PIN, 2) == RX_CH2_PIN
      |-> RX_CH2_DATA == (RX_CH2_PIN ^ c[2])) else $error("rx2 polarity wrong");
   a_tx1_pin: assert property (PORT3_BIT5_PIN_O == (c[4] ? TX_CH1_DATA ^ c[1] : PORT3_BIT5_OUT)
      && PORT3_BIT5_PIN_OE == (c[4] | PORT3_BIT5_DIR)) else $error("port3 pin wrong");
   a_tx2_pin: assert property (PORT4_BIT2_PIN_O == (c[5] ? TX_CH2_DATA ^ c[3] : PORT4_BIT2_OUT)
      && PORT4_BIT2_PIN_OE == (c[5] | PORT4_BIT2_DIR)) else $error("port4 pin wrong");
   a_wake_inv: assert property (age == 2'h3 && $stable(WAKEUP_INPUT_PINS)
      |-> WAKEUP_LEVEL == ($past(WAKEUP_INPUT_PINS) ^ wk) || $past(WAKEUP_INPUT_PINS, 2) != WAKEUP_INPUT_PINS)
      else $error("wake-up level wrong");
   a_ctrl_read: assert property (PSEL && PENABLE && !PWRITE && PADDR == 18'h3fe44
      |-> PRDATA == {24'h0, 2'h3, c}) else $error("control readback wrong");
   a_bus_answer: assert property (PSEL && PENABLE |-> PREADY && PSLVERR == !map) else $error("bus answer wrong");
   a_write_live: assert property (wr && PADDR == 18'h3fe44
      |=> PORT3_BIT5_PIN_OE == ($past(PWDATA[4]) | PORT3_BIT5_DIR)) else $error("write not live");
   c_ctrl_write: cover property (wr && PADDR == 18'h3fe44);
   c_unmapped: cover property (PSLVERR);
   c_both_tx: cover property (c[4] && c[5]);
endmodule // spp_checker
bind spp_top spp_checker u_chk (.*);

// File: verif/spp_far.sv
/* Far-side model: two serial transmitters and the shared pin wires.
   Assumes the bench raises tx_en only after the pin roles are set. */
`timescale 1ns/1ns
module spp_far (
   input  wire logic clk, tx_en, o3, oe3, o4, oe4,
   output logic      tx1, tx2, pin3, pin4
);
   logic [3:0] n = 4'h0; // Bit counter of the frame
   // Transmitters send only once enabled
   always @(posedge clk) n <= tx_en ? n + 4'h1 : 4'h0;
   assign tx1 = tx_en ? n[0] : 1'b1; // Idle line is mark
   assign tx2 = tx_en ? n[1] : 1'b1;
   assign pin3 = oe3 ? o3 : 1'b1; // Pull-up once released
   assign pin4 = oe4 ? o4 : 1'b1;
endmodule // spp_far

// File: verif/testbench.sv
/* Self-checking bench for spp_top: register access over APB, pin paths.
   Assumes spp_checker binds itself and spp_far stands for the far side. */
`timescale 1ns/1ns
module testbench;
   logic CLK = 1'b0, SRST = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, e, ce = 1'b1;
   logic [3:0] strb = 4'hf; // Byte strobes, lane 0 carries the register bits
   logic [17:0] pa = '0;
   logic [31:0] pwd = '0, r;
   logic rx1 = 1'b0, rx2 = 1'b0, p3o = 1'b0, p3d = 1'b0, p4o = 1'b0, p4d = 1'b0, ten = 1'b0;
   logic [7:0] wakeup_input_pins = 8'h00;
   logic [5:0] v;
   wire [31:0] prd;
   wire [7:0] wl;
   wire rdy, err, d1, d2, t1, t2, o3, oe3, o4, oe4, i3, i4, pi3, pi4;
   int bad_count = 0, samples_checked = 0, cyc = 0;
   spp_top u_spp_top (.CLK(CLK), .SRST(SRST), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(pa), .PWDATA(pwd), .PSTRB(strb), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
      .RX_CH1_PIN(rx1), .RX_CH2_PIN(rx2), .RX_CH1_DATA(d1), .RX_CH2_DATA(d2), .TX_CH1_DATA(t1),
      .TX_CH2_DATA(t2), .PORT3_BIT5_OUT(p3o), .PORT3_BIT5_DIR(p3d), .PORT3_BIT5_IN(pi3),
      .PORT4_BIT2_OUT(p4o), .PORT4_BIT2_DIR(p4d), .PORT4_BIT2_IN(pi4), .PORT3_BIT5_PIN_I(i3),
      .PORT3_BIT5_PIN_O(o3), .PORT3_BIT5_PIN_OE(oe3), .PORT4_BIT2_PIN_I(i4), .PORT4_BIT2_PIN_O(o4),
      .PORT4_BIT2_PIN_OE(oe4), .WAKEUP_INPUT_PINS(wakeup_input_pins), .WAKEUP_LEVEL(wl));
   spp_far u_far (.clk(CLK), .tx_en(ten), .o3(o3), .oe3(oe3), .o4(o4), .oe4(oe4),
      .tx1(t1), .tx2(t2), .pin3(i3), .pin4(i4));
   initial forever #5 CLK = ~CLK;
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   // One APB transfer; result left in r and e
   task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
      @(posedge CLK);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge CLK);
      pen <= 1'b1;
      do @(posedge CLK); while (rdy !== 1'b1);
      r = prd;
      e = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task summarize;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      repeat (16) @(posedge CLK);
      SRST <= 1'b0;
      apb(1'b0, 18'h3fe44, 0); chk(r, 32'hc0);
      apb(1'b1, 18'h3fe44, 32'hff);
      apb(1'b0, 18'h3fe44, 0); chk(r, 32'hff);
      apb(1'b1, 18'h3fe44, 0);
      apb(1'b0, 18'h3fe44, 0); chk(r, 32'hc0);
      apb(1'b0, 18'h00010, 0); chk({r[30:0], e}, 32'h1); // Unmapped: zero data, error
      // Lane 0 strobe off, then clock enable low: neither write may land
      strb <= 4'he;
      apb(1'b1, 18'h3fe44, 32'h3f);
      strb <= 4'hf;
      ce <= 1'b0;
      apb(1'b1, 18'h3fe44, 32'h3f);
      ce <= 1'b1;
      apb(1'b0, 18'h3fe44, 0); chk(r, 32'hc0);
      // Every control setting against the receive paths and the shared-pin output paths
      for (int i = 0; i < 64; i++) begin
         // Leave the negative edge so stimulus moves on a rising edge
         @(posedge CLK);
         v = i[5:0];
         ten <= 1'b0;
         apb(1'b1, 18'h3fe44, {26'h0, v});
         ten <= v[4] & v[5];
         rx1 <= ^v;
         rx2 <= v[0];
         p3o <= v[3];
         p3d <= v[5];
         p4o <= v[1];
         p4d <= v[0];
         repeat (3) @(posedge CLK);
         @(negedge CLK);
         chk(d1, rx1 ^ v[0]);
         chk(d2, rx2 ^ v[2]);
         chk(o3, v[4] ? t1 ^ v[1] : p3o);
         chk(oe3, v[4] | p3d);
         chk(o4, v[5] ? t2 ^ v[3] : p4o);
         chk(oe4, v[5] | p4d);
      end
      apb(1'b1, 18'h3fe4c, 32'h5a);
      wakeup_input_pins <= 8'ha5;
      repeat (3) @(posedge CLK);
      @(negedge CLK);
      chk(wl, 32'hff);
      // Shared pins back to port role; status shows raw pin levels
      @(posedge CLK);
      ten <= 1'b0;
      rx1 <= 1'b1;
      rx2 <= 1'b0;
      p3d <= 1'b0;
      p4d <= 1'b1;
      p4o <= 1'b0;
      apb(1'b1, 18'h3fe44, 0);
      repeat (3) @(posedge CLK);
      apb(1'b0, 18'h3fe50, 0); chk(r, 32'ha505); // Raw pin levels, un-inverted
      chk({pi3, pi4}, 32'h2); // Released pin pulled up, driven pin low
      chk(d1, 32'h1);
      apb(1'b0, 18'h3fe4c, 0); chk(r, 32'h5a);
      summarize();
   end
endmodule // testbench

// File: verilog/spp_defines.vh
/*
 * Constants for the serial pin polarity select block: register indices,
 * field positions, reset values and bus widths.
 * Assumes it is included by bare name from files in the same folder.
 */
`ifndef SPP_DEFINES_VH
`define SPP_DEFINES_VH

// Bus widths
`define SPP_ADDR_W          18
`define SPP_DATA_W          32

// Register indices (byte address is four times the index)
`define SPP_IDX_CTRL        16'hff91
`define SPP_IDX_WAKE_INV    16'hff93
`define SPP_IDX_STATUS      16'hff94

// Control register field positions
`define SPP_RX1_INV_BIT     0
`define SPP_TX1_INV_BIT     1
`define SPP_RX2_INV_BIT     2
`define SPP_TX2_INV_BIT     3
`define SPP_TX1_SEL_BIT     4
`define SPP_TX2_SEL_BIT     5
`define SPP_CTRL_RW_W       6

// Reset and fixed values
`define SPP_CTRL_RESET      8'hc0
`define SPP_CTRL_RSVD       2'h3
`define SPP_WAKE_RESET      8'h00

// Synchroniser depth for pin inputs
`define SPP_SYNC_STAGES     2

`endif

// File: verilog/spp_sync.v
/*
 * Two-flop level synchroniser, one lane per bit.
 * Assumes inputs are asynchronous levels and CE freezes its state.
 */
`timescale 1ns/1ns

module spp_sync #(
   parameter WIDTH = 1                  // Number of lanes
) (
   // Clock and control
   input  wire             clk,
   input  wire             srst,
   input  wire             ce,
   // Data
   input  wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] dout
);

   genvar i;

   // One independent pair of flops per lane
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
         reg meta;                      // First stage, read only by second
         reg stable;                    // Second stage, safe to use

         // Chain of two flops; reset to zero for a defined start
         always @(posedge clk) begin
            if (srst) begin
               meta   <= 1'b0;
               stable <= 1'b0;
            end else if (ce) begin
               meta   <= din[i];
               stable <= meta;
            end
         end

         assign dout[i] = stable;
      end
   endgenerate

endmodule // spp_sync

// File: verilog/spp_top.v
/*
 * Serial pin polarity and function select, with an APB register slave.
 * Holds the control register for receive/transmit inversion and for the
 * role of the two shared transmit pins, wake-up input inversion, and a
 * status register of synchronised pin levels.
 * Assumes one clock CLK, synchronous reset SRST, and serial units and a
 * port block on the same clock driving the transmit and port data.
 * CE low holds every flop; SRST still acts while CE is low.
 */
// Behaviour
// - Bit 0 inverts channel 1 receive
// - Bit 1 inverts channel 1 transmit
// - Bit 2 inverts channel 2 receive
// - Bit 3 inverts channel 2 transmit
// - Top two bits read one, ignore writes
// - Control register resets to c0
// - Register writes reach pins immediately
// - Wake-up inputs can be inverted
`timescale 1ns/1ns
`include "spp_defines.vh"

module spp_top (
   // Clock, reset, enable
   input  wire                    CLK,
   input  wire                    SRST,
   input  wire                    CE,
   // APB slave
   input  wire                    PSEL,
   input  wire                    PENABLE,
   input  wire                    PWRITE,
   input  wire [`SPP_ADDR_W-1:0]  PADDR,
   input  wire [`SPP_DATA_W-1:0]  PWDATA,
   input  wire [3:0]              PSTRB,
   output reg  [`SPP_DATA_W-1:0]  PRDATA,
   output wire                    PREADY,
   output wire                    PSLVERR,
   // Receive pins and serial unit receive inputs
   input  wire                    RX_CH1_PIN,
   input  wire                    RX_CH2_PIN,
   output wire                    RX_CH1_DATA,
   output wire                    RX_CH2_DATA,
   // Serial unit transmit data
   input  wire                    TX_CH1_DATA,
   input  wire                    TX_CH2_DATA,
   // General-purpose port side of the shared pins
   input  wire                    PORT3_BIT5_OUT,
   input  wire                    PORT3_BIT5_DIR,
   output wire                    PORT3_BIT5_IN,
   input  wire                    PORT4_BIT2_OUT,
   input  wire                    PORT4_BIT2_DIR,
   output wire                    PORT4_BIT2_IN,
   // Shared pin port 3 bit 5 / channel 1 transmit
   input  wire                    PORT3_BIT5_PIN_I,
   output wire                    PORT3_BIT5_PIN_O,
   output wire                    PORT3_BIT5_PIN_OE,
   // Shared pin port 4 bit 2 / channel 2 transmit
   input  wire                    PORT4_BIT2_PIN_I,
   output wire                    PORT4_BIT2_PIN_O,
   output wire                    PORT4_BIT2_PIN_OE,
   // Wake-up pins and their levels for internal logic
   input  wire [7:0]              WAKEUP_INPUT_PINS,
   output wire [7:0]              WAKEUP_LEVEL
);

   // Register state
   reg  [`SPP_CTRL_RW_W-1:0] ctrl;          // Writable control bits
   reg  [7:0]                wake_inv;      // Wake-up inversion mask

   // Reset image of the whole register; the reserved top bits are
   // never stored, so only the low writable slice is loaded
   localparam [7:0]          ctrl_reset_val = `SPP_CTRL_RESET;

   // Synchronised pin levels
   wire [11:0]               pin_sync;      // All asynchronous pins
   wire                      rx1_s;         // Channel 1 receive pin
   wire                      rx2_s;         // Channel 2 receive pin
   wire                      p35_s;         // Port 3 bit 5 pin
   wire                      p42_s;         // Port 4 bit 2 pin
   wire [7:0]                wake_s;        // Wake-up pins

   // Bus decode
   wire                      setup_ph;      // APB setup cycle
   wire                      access_ph;     // APB access cycle
   wire                      hit_ctrl;      // Control register addressed
   wire                      hit_wake;      // Wake-up register addressed
   wire                      hit_stat;      // Status register addressed
   wire                      mapped;        // Any register addressed
   wire [7:0]                ctrl_view;     // Control as software sees it
   reg  [`SPP_DATA_W-1:0]    next_prdata;   // Read data chosen in setup

   // Word address match against a register index. The full address
   // is compared, so a register has no aliases and any other
   // address ends with an error response
   function addr_hit;
      input [`SPP_ADDR_W-1:0] addr;
      input [15:0]            idx;
      begin
         addr_hit = (addr == {idx, 2'b00});
      end
   endfunction

   // Every pin from outside is brought into the clock domain first.
   // The two flops cost two cycles of receive latency; that is small
   // against a serial bit time and keeps metastability out of the XOR
   spp_sync #(
      .WIDTH (12)
   ) u_sync (
      .clk  (CLK),
      .srst (SRST),
      .ce   (CE),
      .din  ({WAKEUP_INPUT_PINS, PORT4_BIT2_PIN_I, PORT3_BIT5_PIN_I,
              RX_CH2_PIN, RX_CH1_PIN}),
      .dout (pin_sync)
   );

   assign rx1_s  = pin_sync[0];
   assign rx2_s  = pin_sync[1];
   assign p35_s  = pin_sync[2];
   assign p42_s  = pin_sync[3];
   assign wake_s = pin_sync[11:4];

   // Receive path: synchronised level, then a bare XOR so the bit
   // adds no further cycle on the way to the serial unit
   assign RX_CH1_DATA = rx1_s ^ ctrl[`SPP_RX1_INV_BIT];
   assign RX_CH2_DATA = rx2_s ^ ctrl[`SPP_RX2_INV_BIT];

   // Transmit path onto shared pins. In transmit role the pin is
   // always driven; the serial unit idles its line high itself.
   // Software must select the pin before it enables the transmitter,
   // else the first bits go out on the port bit instead.
   assign PORT3_BIT5_PIN_O  = ctrl[`SPP_TX1_SEL_BIT] ?
                              (TX_CH1_DATA ^ ctrl[`SPP_TX1_INV_BIT]) :
                              PORT3_BIT5_OUT;
   assign PORT3_BIT5_PIN_OE = ctrl[`SPP_TX1_SEL_BIT] | PORT3_BIT5_DIR;
   assign PORT4_BIT2_PIN_O  = ctrl[`SPP_TX2_SEL_BIT] ?
                              (TX_CH2_DATA ^ ctrl[`SPP_TX2_INV_BIT]) :
                              PORT4_BIT2_OUT;
   assign PORT4_BIT2_PIN_OE = ctrl[`SPP_TX2_SEL_BIT] | PORT4_BIT2_DIR;

   // Port side always sees the true pin level, whatever the role,
   // so the port block can read back what the pin really shows
   assign PORT3_BIT5_IN = p35_s;
   assign PORT4_BIT2_IN = p42_s;

   // Wake-up levels, inverted per bit under the mask. The mask resets
   // to zero so the wake-up logic first sees true pin levels
   assign WAKEUP_LEVEL = wake_s ^ wake_inv;

   // APB phases and address decode
   // Purely combinational from the bus inputs
   assign setup_ph  = PSEL & ~PENABLE;
   assign access_ph = PSEL & PENABLE;
   assign hit_ctrl  = addr_hit(PADDR, `SPP_IDX_CTRL);
   assign hit_wake  = addr_hit(PADDR, `SPP_IDX_WAKE_INV);
   assign hit_stat  = addr_hit(PADDR, `SPP_IDX_STATUS);
   assign mapped    = hit_ctrl | hit_wake | hit_stat;

   // Zero wait states; unmapped addresses end with an error
   // The block has no slow state, so a wait would buy nothing
   assign PREADY  = 1'b1;
   assign PSLVERR = access_ph & ~mapped;

   // Reserved top bits are constant ones, never stored
   assign ctrl_view = {`SPP_CTRL_RSVD, ctrl};

   // Read mux, sampled in the setup cycle so PRDATA comes from a flop
   always @* begin
      next_prdata = {`SPP_DATA_W{1'b0}};
      if (hit_ctrl) begin
         next_prdata = {24'h000000, ctrl_view};
      end else if (hit_wake) begin
         next_prdata = {24'h000000, wake_inv};
      end else if (hit_stat) begin
         // Raw synchronised pin levels, before any inversion:
         // bits 0 and 1 the receive pins, 2 and 3 the shared pins,
         // 15:8 the wake-up pins; lets software spot a line idling
         // at the wrong level before it chooses a polarity
         next_prdata = {16'h0000, wake_s, 4'h0, p42_s, p35_s, rx2_s, rx1_s};
      end else begin
         // Unmapped: reads as zero
         next_prdata = {`SPP_DATA_W{1'b0}};
      end
   end

   // Read data register. Loading in the setup cycle lets PRDATA come
   // from a flop and still stand for the whole access cycle
   always @(posedge CLK) begin
      if (SRST) begin
         PRDATA <= {`SPP_DATA_W{1'b0}};
      end else if (CE) begin
         if (setup_ph & ~PWRITE) begin
            PRDATA <= next_prdata;
         end
      end
   end

   // Register writes in the access cycle; byte lane 0 carries all bits.
   // The new value acts on the pins from the next edge on, with no
   // staging, so a frame in flight can see a false edge.
   always @(posedge CLK) begin
      if (SRST) begin
         ctrl     <= ctrl_reset_val[`SPP_CTRL_RW_W-1:0];
         wake_inv <= `SPP_WAKE_RESET;
      end else if (CE) begin
         // Only byte lane 0 holds register bits; a write with that
         // lane off leaves both registers untouched
         if (access_ph & PWRITE & PSTRB[0]) begin
            if (hit_ctrl) begin
               ctrl <= PWDATA[`SPP_CTRL_RW_W-1:0];
            end
            if (hit_wake) begin
               wake_inv <= PWDATA[7:0];
            end
         end
      end
   end

endmodule // spp_top
